/* common/accel_i2c_consts.svh */
// constants for the sensor i2c slave readout block
// assumes inclusion by bare name from design files
`ifndef ACCEL_I2C_CONSTS_SVH
`define ACCEL_I2C_CONSTS_SVH

`define ADDR_UPPER        4'h2
`define CTRL_OFFSET       3'h0
`define XT_HIGH_OFFSET    3'h1
`define XT_LOW_OFFSET     3'h2
`define Y_HIGH_OFFSET     3'h3
`define Y_LOW_OFFSET      3'h4
`define CTRL_RESET        8'h00
`define SLEEP_BIT         0
`define SELF_CHECK_BIT    1
`define REF_TRIM_BIT      2
`define THERMAL_SEL_BIT   3
`define SAMPLE_RESET      12'h000

`endif

/* common/accel_i2c_pkg.sv */
// types for the sensor i2c slave readout block
// constants live in accel_i2c_consts.svh
package accel_i2c_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_ADACK  = 3'b011,
        ST_WRITE  = 3'b010,
        ST_WRACK  = 3'b110,
        ST_READ   = 3'b111,
        ST_RDACK  = 3'b101,
        ST_IGNORE = 3'b100
    } slave_state_t;

    typedef struct packed {
        logic [2:0] stage;
        logic [2:0] stage_d;
    } sync_state_t;

endpackage : accel_i2c_pkg

/* design/pin_sync.sv */
// two flip-flop synchroniser for the serial clock and data pins
// assumes pins idle high under a pull-up
`timescale 1ns/1ps
module pin_sync
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // raw pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // synchronised levels
    output logic            scl_sync,
    output logic            sda_sync
);
    typedef struct packed {
        logic [1:0] scl;
        logic [1:0] sda;
    } sync_reg_t;

    sync_reg_t sync_reg;
    sync_reg_t sync_next;

    always_comb
    begin
        sync_next.scl = {sync_reg.scl[0], scl_in};
        sync_next.sda = {sync_reg.sda[0], sda_in};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg <= '{scl: 2'h3, sda: 2'h3};
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    // only the second stage is read, the first may be metastable
    assign scl_sync = sync_reg.scl[1];
    assign sda_sync = sync_reg.sda[1];
endmodule : pin_sync

/* design/accel_i2c_slave_readout.sv */
// i2c slave front end of a dual-axis acceleration sensor
// assumes scl well below core_clk/8 and samples on the core clock
`timescale 1ns/1ps
`include "accel_i2c_consts.svh"
module accel_i2c_slave_readout
#(
    parameter int SAMPLE_BITS = 12
)
(
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // factory address bits
    input  wire logic [2:0]             addr_strap,
    // i2c pins
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe_n,
    // conversion results, same clock domain
    input  wire logic [SAMPLE_BITS-1:0] x_sample,
    input  wire logic [SAMPLE_BITS-1:0] y_sample,
    input  wire logic [SAMPLE_BITS-1:0] thermal_result,
    // control outputs
    output logic                        sleep_request,
    output logic                        self_check_enable,
    output logic                        reference_trim_test,
    output logic                        thermal_output_select
);
    typedef struct packed {
        accel_i2c_pkg::slave_state_t state;
        logic                        scl_d;
        logic                        sda_d;
        logic [3:0]                  bit_cnt;
        logic [7:0]                  shift;
        logic [2:0]                  pointer;
        logic                        ptr_phase;
        logic                        rd_dir;
        logic [7:0]                  ctrl;
        logic [7:0]                  low_hold;
        logic                        sda_low;
    } core_state_t;

    core_state_t cur_reg;
    core_state_t cur_next;
    logic        scl_s;
    logic        sda_s;

    pin_sync u_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .scl_sync (scl_s),
        .sda_sync (sda_s)
    );

    // zero-extend a sample into the 16-bit byte pair
    function automatic logic [15:0] widen
    (
        input logic [SAMPLE_BITS-1:0] v
    );
        widen = 16'(v);
    endfunction : widen

    // byte at a map position; low bytes come from the held copy
    function automatic logic [7:0] map_byte
    (
        input logic [2:0] pos,
        input logic [7:0] ctrl,
        input logic [7:0] held
    );
        logic [15:0] xt;
        logic [15:0] yy;
        xt = ctrl[`THERMAL_SEL_BIT] ? widen(thermal_result)
                                    : widen(x_sample);
        yy = widen(y_sample);
        case (pos)
            `CTRL_OFFSET:    map_byte = ctrl;
            `XT_HIGH_OFFSET: map_byte = xt[15:8];
            `Y_HIGH_OFFSET:  map_byte = yy[15:8];
            `XT_LOW_OFFSET,
            `Y_LOW_OFFSET:   map_byte = held;
            default:         map_byte = 8'h00;
        endcase
    endfunction : map_byte

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [15:0] xt_now;
    logic [15:0] y_now;
    logic [7:0]  rd_byte;
    logic [7:0]  lo_byte;

    always_comb
    begin
        scl_rise   = scl_s && !cur_reg.scl_d;
        scl_fall   = !scl_s && cur_reg.scl_d;
        start_seen = scl_s && cur_reg.scl_d && cur_reg.sda_d && !sda_s;
        stop_seen  = scl_s && cur_reg.scl_d && !cur_reg.sda_d && sda_s;
        xt_now     = cur_reg.ctrl[`THERMAL_SEL_BIT] ? widen(thermal_result)
                                                    : widen(x_sample);
        y_now      = widen(y_sample);
        rd_byte    = map_byte(cur_reg.pointer, cur_reg.ctrl,
                              cur_reg.low_hold);
        lo_byte    = (cur_reg.pointer == `XT_HIGH_OFFSET) ? xt_now[7:0]
                                                          : y_now[7:0];
    end

    always_comb
    begin
        cur_next       = cur_reg;
        cur_next.scl_d = scl_s;
        cur_next.sda_d = sda_s;
        if (start_seen)
        begin
            cur_next.state   = accel_i2c_pkg::ST_ADDR;
            cur_next.bit_cnt = 4'h0;
            cur_next.sda_low = 1'b0;
        end
        else if (stop_seen)
        begin
            cur_next.state   = accel_i2c_pkg::ST_IDLE;
            cur_next.sda_low = 1'b0;
        end
        else
        begin
            case (cur_reg.state)
                accel_i2c_pkg::ST_IDLE,
                accel_i2c_pkg::ST_IGNORE:
                begin
                    cur_next.sda_low = 1'b0;
                end
                accel_i2c_pkg::ST_ADDR,
                accel_i2c_pkg::ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        // msb first shift on rising edge
                        cur_next.shift   = {cur_reg.shift[6:0], sda_s};
                        cur_next.bit_cnt = cur_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && cur_reg.bit_cnt == 4'h8)
                    begin
                        cur_next.bit_cnt = 4'h0;
                        if (cur_reg.state == accel_i2c_pkg::ST_ADDR)
                        begin
                            if (cur_reg.shift[7:1] == {`ADDR_UPPER, addr_strap})
                            begin
                                cur_next.rd_dir    = cur_reg.shift[0];
                                cur_next.ptr_phase = 1'b1;
                                cur_next.sda_low   = 1'b1;
                                cur_next.state     = accel_i2c_pkg::ST_ADACK;
                            end
                            else
                            begin
                                cur_next.state = accel_i2c_pkg::ST_IGNORE;
                            end
                        end
                        else if (cur_reg.ptr_phase)
                        begin
                            cur_next.pointer   = cur_reg.shift[2:0];
                            cur_next.ptr_phase = 1'b0;
                            cur_next.sda_low   = 1'b1;
                            cur_next.state     = accel_i2c_pkg::ST_WRACK;
                        end
                        else if (cur_reg.pointer == `CTRL_OFFSET)
                        begin
                            cur_next.ctrl    = cur_reg.shift;
                            cur_next.sda_low = 1'b1;
                            cur_next.state   = accel_i2c_pkg::ST_WRACK;
                        end
                        else
                        begin
                            // nonzero pointer: leave control alone, no ack
                            cur_next.state = accel_i2c_pkg::ST_IGNORE;
                        end
                    end
                end
                accel_i2c_pkg::ST_ADACK,
                accel_i2c_pkg::ST_WRACK:
                begin
                    if (scl_fall)
                    begin
                        if (cur_reg.state == accel_i2c_pkg::ST_ADACK
                            && cur_reg.rd_dir)
                        begin
                            cur_next.shift   = rd_byte;
                            cur_next.sda_low = !rd_byte[7];
                            cur_next.state   = accel_i2c_pkg::ST_READ;
                        end
                        else
                        begin
                            cur_next.sda_low = 1'b0;
                            cur_next.state   = accel_i2c_pkg::ST_WRITE;
                        end
                        cur_next.bit_cnt = 4'h0;
                    end
                end
                accel_i2c_pkg::ST_READ:
                begin
                    if (scl_fall)
                    begin
                        cur_next.bit_cnt = cur_reg.bit_cnt + 4'h1;
                        cur_next.shift   = {cur_reg.shift[6:0], 1'b0};
                        if (cur_reg.bit_cnt == 4'h7)
                        begin
                            cur_next.sda_low = 1'b0;
                            cur_next.state   = accel_i2c_pkg::ST_RDACK;
                            cur_next.pointer = cur_reg.pointer + 3'h1;
                        end
                        else
                        begin
                            cur_next.sda_low = !cur_reg.shift[6];
                        end
                    end
                end
                accel_i2c_pkg::ST_RDACK:
                begin
                    if (scl_rise)
                    begin
                        // master ack continues, nack releases the bus
                        cur_next.rd_dir = !sda_s;
                    end
                    else if (scl_fall)
                    begin
                        cur_next.bit_cnt = 4'h0;
                        if (cur_reg.rd_dir)
                        begin
                            cur_next.shift   = rd_byte;
                            cur_next.sda_low = !rd_byte[7];
                            cur_next.state   = accel_i2c_pkg::ST_READ;
                        end
                        else
                        begin
                            cur_next.state = accel_i2c_pkg::ST_IGNORE;
                        end
                    end
                end
                default:
                begin
                    cur_next.state = accel_i2c_pkg::ST_IDLE;
                end
            endcase
            // take the low byte in the cycle its high byte is loaded, so a
            // conversion landing in between cannot split the pair
            if (cur_next.state == accel_i2c_pkg::ST_READ
                && cur_reg.state != accel_i2c_pkg::ST_READ
                && (cur_reg.pointer == `XT_HIGH_OFFSET
                    || cur_reg.pointer == `Y_HIGH_OFFSET))
                cur_next.low_hold = lo_byte;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_reg <= '{state:     accel_i2c_pkg::ST_IDLE,
                         scl_d:     1'b1,
                         sda_d:     1'b1,
                         bit_cnt:   4'h0,
                         shift:     8'h00,
                         pointer:   `CTRL_OFFSET,
                         ptr_phase: 1'b0,
                         rd_dir:    1'b0,
                         ctrl:      `CTRL_RESET,
                         low_hold:  8'h00,
                         sda_low:   1'b0};
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    // open-drain: only ever drive low
    assign sda_out               = 1'b0;
    assign sda_oe_n              = !cur_reg.sda_low;
    assign sleep_request         = cur_reg.ctrl[`SLEEP_BIT];
    assign self_check_enable     = cur_reg.ctrl[`SELF_CHECK_BIT];
    assign reference_trim_test   = cur_reg.ctrl[`REF_TRIM_BIT];
    assign thermal_output_select = cur_reg.ctrl[`THERMAL_SEL_BIT];
endmodule : accel_i2c_slave_readout

/* tb/accel_i2c_checker.sv */
// assertions watching the pins of the sensor i2c readout block
// assumes raw pin levels and scl far slower than core_clk
`timescale 1ns/1ps
`include "accel_i2c_consts.svh"
module accel_i2c_checker
#(
    parameter int SAMPLE_BITS = 12
)
(
    // clock and reset
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    // pins and strap
    input wire logic [2:0]             addr_strap,
    input wire logic                   scl_in,
    input wire logic                   sda_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe_n,
    // samples
    input wire logic [SAMPLE_BITS-1:0] x_sample,
    input wire logic [SAMPLE_BITS-1:0] y_sample,
    input wire logic [SAMPLE_BITS-1:0] thermal_result,
    // control outputs
    input wire logic                   sleep_request,
    input wire logic                   self_check_enable,
    input wire logic                   reference_trim_test,
    input wire logic                   thermal_output_select
);
    logic       scl_q, sda_q, rw, hit, rise, fall, st, me;
    logic [3:0] bc, ctl;
    logic [2:0] by;
    logic [7:0] sh, ptr;
    assign rise = scl_in & ~scl_q;
    assign fall = ~scl_in & scl_q;
    assign st   = scl_in & scl_q & sda_q & ~sda_in;
    assign me   = sh[7:1] == {`ADDR_UPPER, addr_strap};
    assign ctl  = {thermal_output_select, reference_trim_test,
                   self_check_enable, sleep_request};
    // bus monitor; byte count saturates so a long read never looks
    // like a fresh address byte
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {scl_q, sda_q} <= 2'h3;
            {rw, hit, bc, by, sh, ptr} <= 25'h0;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            if (st)
            begin
                bc <= 4'h0;
                by <= 3'h0;
            end
            else if (rise)
            begin
                sh <= {sh[6:0], sda_in};
                bc <= (bc == 4'h8) ? 4'h0 : bc + 4'h1;
                if (bc == 4'h8 && by != 3'h7)
                    by <= by + 3'h1;
                if (bc == 4'h8 && by == 3'h0)
                    {hit, rw} <= {me, sh[0]};
                if (bc == 4'h8 && by == 3'h1)
                    ptr <= sh;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_ninth;
        rise && bc == 4'h8;
    endsequence
    sequence s_addr_done;
        fall && bc == 4'h8 && by == 3'h0 && me;
    endsequence
    a_drive_low_only: assert property (!sda_oe_n |-> !sda_out)
        else $error("data pin driven high");
    a_ack_own_addr: assert property (s_ninth ##0 by == 3'h0 |-> sda_oe_n == !me)
        else $error("address acknowledge wrong");
    a_ack_in_time: assert property (s_addr_done |-> ##[1:6] !sda_oe_n)
        else $error("address acknowledge late");
    a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data changed while scl high");
    a_ctrl_at_ack: assert property ($changed(ctl) |-> !sda_oe_n && !scl_in)
        else $error("control changed outside acknowledge");
    a_write_bits_quiet: assert property (rise && bc < 4'h8 && by != 3'h0 && !rw |-> sda_oe_n)
        else $error("device drove data in a write");
    a_ack_pointer: assert property (s_ninth ##0 (by == 3'h1 && hit && !rw) |-> !sda_oe_n)
        else $error("pointer byte not acknowledged");
    a_refuse_data: assert property (s_ninth ##0 (by == 3'h2 && hit && !rw && ptr != 8'h00) |-> sda_oe_n)
        else $error("data after nonzero pointer acknowledged");
    a_reset_idle: assert property ($rose(rst_n) |-> sda_oe_n && ctl == 4'h0)
        else $error("outputs not idle after reset");
endmodule : accel_i2c_checker

bind accel_i2c_slave_readout accel_i2c_checker #(
    .SAMPLE_BITS(SAMPLE_BITS)
) chk (
    .core_clk(core_clk), .rst_n(rst_n), .addr_strap(addr_strap),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .x_sample(x_sample), .y_sample(y_sample),
    .thermal_result(thermal_result), .sleep_request(sleep_request),
    .self_check_enable(self_check_enable),
    .reference_trim_test(reference_trim_test),
    .thermal_output_select(thermal_output_select)
);

/* tb/i2c_master_model.sv */
// behavioural i2c bus master for the sensor readout block
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/1ps
module i2c_master_model
#(
    parameter int HALF = 10
)
(
    // clock
    input  wire logic core_clk,
    // bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    logic [7:0] res = 8'h00;
    event       got;
    initial
    begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic half;
        repeat (HALF) @(posedge core_clk);
    endtask : half
    task automatic start;
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask : start
    task automatic stop;
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask : stop
    // data moves only while scl is low, read just before the fall
    task automatic xbit(input logic b, output logic r);
        sda_drv <= b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
        half();
    endtask : xbit
    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] b, input logic a,
                           input logic rd);
        logic       r;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--)
        begin
            xbit(b[i], r);
            d[i] = r;
        end
        xbit(a, r);
        res = rd ? d : {7'h00, r};
        -> got;
    endtask : byte_io
endmodule : i2c_master_model

/* tb/accel_i2c_slave_readout_tb.sv */
// self-checking bench for the sensor i2c readout block
// assumes the master model and the checker bind are compiled first
`timescale 1ns/1ps
`include "accel_i2c_consts.svh"
module accel_i2c_slave_readout_tb;
    localparam logic [2:0] STRAP = 3'h5;
    // power-up and acquisition waits belong to the analog side; a short
    // idle gap on the bus stands in for them
    localparam int         WAKE_GAP = 100;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        scl, sda, sda_drv, sda_out, sda_oe_n;
    logic        sleep, selfc, trim, therm;
    logic [11:0] x_s = 12'h000, y_s = 12'h000, t_s = 12'h000;
    logic [7:0]  ctrl_exp = 8'h00;
    logic [7:0]  exp_q[$];
    logic [16:0] seed = 17'h13811;
    int          failures = 0;
    int          compares = 0;
    assign sda = sda_drv & (sda_oe_n | sda_out);
    always #20 core_clk = ~core_clk;
    accel_i2c_slave_readout DUT (
        .core_clk(core_clk), .rst_n(rst_n), .addr_strap(STRAP),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .x_sample(x_s), .y_sample(y_s),
        .thermal_result(t_s), .sleep_request(sleep),
        .self_check_enable(selfc), .reference_trim_test(trim),
        .thermal_output_select(therm));
    i2c_master_model m (.core_clk(core_clk), .sda(sda), .scl(scl),
                        .sda_drv(sda_drv));
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic ck_ctrl;
        check({4'h0, therm, trim, selfc, sleep},
              {4'h0, ctrl_exp[3:0]});
    endtask : ck_ctrl
    task automatic stir;
        seed = lfsr(seed);
        x_s <= seed[11:0];
        seed = lfsr(seed);
        y_s <= seed[11:0];
        seed = lfsr(seed);
        t_s <= seed[11:0];
    endtask : stir
    // address with direction bit low, pointer, optional data byte
    task automatic wr(input logic [7:0] p, input logic dat,
                      input logic [7:0] v, input logic [7:0] dack);
        m.start();
        exp_q.push_back(8'h00);
        m.byte_io({`ADDR_UPPER, STRAP, 1'b0}, 1'b1, 1'b0);
        exp_q.push_back(8'h00);
        m.byte_io(p, 1'b1, 1'b0);
        if (dat)
        begin
            exp_q.push_back(dack);
            m.byte_io(v, 1'b1, 1'b0);
        end
        m.stop();
    endtask : wr
    // samples change before low bytes to prove the pair stays coherent
    task automatic rd(input logic [2:0] p, input int n);
        logic [2:0]  pos;
        logic [11:0] xt, yl;
        logic [7:0]  e;
        pos = p;
        wr({5'h00, p}, 1'b0, 8'h00, 8'h00);
        m.start();
        exp_q.push_back(8'h00);
        m.byte_io({`ADDR_UPPER, STRAP, 1'b1}, 1'b1, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            if (pos == 3'h2 || pos == 3'h4)
                stir();
            if (pos == 3'h1)
                xt = ctrl_exp[`THERMAL_SEL_BIT] ? t_s : x_s;
            if (pos == 3'h3)
                yl = y_s;
            case (pos)
                3'h0: e = ctrl_exp;
                3'h1: e = {4'h0, xt[11:8]};
                3'h2: e = xt[7:0];
                3'h3: e = {4'h0, yl[11:8]};
                3'h4: e = yl[7:0];
                default: e = 8'h00;
            endcase
            exp_q.push_back(e);
            m.byte_io(8'hFF, i == n - 1, 1'b1);
            pos = pos + 3'h1;
        end
        m.stop();
    endtask : rd
    always @(m.got)
        check(m.res, exp_q.pop_front());
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        ck_ctrl();
        for (int i = 0; i < 5; i++)
        begin
            seed = lfsr(seed);
            ctrl_exp = (i < 4) ? (8'h01 << i) : seed[7:0];
            wr(8'h00, 1'b1, ctrl_exp, 8'h00);
            ck_ctrl();
            repeat (WAKE_GAP) @(posedge core_clk);
            rd(3'h0, 1);
        end
        $display("test control done");
        stir();
        ctrl_exp = 8'h00;
        wr(8'h00, 1'b1, ctrl_exp, 8'h00);
        rd(3'h0, 9);
        ctrl_exp = 8'h08;
        wr(8'h00, 1'b1, ctrl_exp, 8'h00);
        rd(3'h1, 4);
        // one temperature reading with the bandgap bit set, one without
        for (int b = 0; b < 2; b++)
        begin
            ctrl_exp = b ? 8'h08 : 8'h0C;
            wr(8'h00, 1'b1, ctrl_exp, 8'h00);
            ck_ctrl();
            rd(3'h1, 2);
        end
        $display("test burst done");
        wr(8'h03, 1'b1, 8'h01, 8'h01);
        ck_ctrl();
        m.start();
        exp_q.push_back(8'h01);
        m.byte_io({`ADDR_UPPER, STRAP ^ 3'h1, 1'b0}, 1'b1, 1'b0);
        m.stop();
        rd(3'h3, 2);
        $display("test refusal done");
        close_out();
    end
endmodule : accel_i2c_slave_readout_tb
